// ### shared/flash_mode_regs.svh
`ifndef FLASH_MODE_REGS_SVH
`define FLASH_MODE_REGS_SVH

// Register byte offsets
`define OFF_CMD       5'h00
`define OFF_CFG       5'h04
`define OFF_SR1       5'h08
`define OFF_STAT      5'h0c
`define OFF_PADDR     5'h10
`define OFF_PDATA     5'h14
`define OFF_INFO      5'h18

// Command field positions in a command write
`define CMD_OP_MSB    7
`define CMD_LANE_LSB  8

// Opcodes
`define OP_WREN       8'h06
`define OP_WRDI       8'h04
`define OP_VWREN      8'h50
`define OP_RSTEN      8'h66
`define OP_RST        8'h99
`define OP_EN4B       8'hb7
`define OP_SLEEP      8'hb9

// Status register 1 volatile mask, lane mode reset value
`define SR1_VOL_MASK  8'h03
`define LANE_RESET    2'h0

// Parameter table window
`define PT_BASE       9'h137
`define PT_LAST       9'h13f

// Wake-up delay: (count + 1) * unit
`define WAKE_UNIT_CODE 2'h3
`define WAKE_COUNT     6
`define WAKE_TIME_NS   448000
`define CLK_PERIOD_NS  25
`define WAKE_UNIT_NS  ((`WAKE_UNIT_CODE == 2'h0) ? 128 : (`WAKE_UNIT_CODE == 2'h1) ? 1000 : \
                       (`WAKE_UNIT_CODE == 2'h2) ? 8000 : 64000)
`define WAKE_DELAY_NS ((`WAKE_COUNT + 1) * `WAKE_UNIT_NS)
`define WAKE_CYCLES   ((`WAKE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### shared/flash_mode_pkg.sv
`default_nettype none
package flash_mode_pkg;

  typedef enum logic [2:0] {
    ACTIVE = 3'h1,
    SLEEP  = 3'h2,
    WAKING = 3'h4
  } power_t;

  typedef struct packed {
    logic       cmdRefused;
    logic       rstEnable;
    logic       volActive;
    logic       wel;
    logic       waking;
    logic       deepSleep;
    logic       addr4;
    logic [7:0] sr1;
  } status_t;

  typedef struct packed {
    logic [2:0] addrBytes;
    logic [7:0] opcode;
  } cmd_info_t;

endpackage : flash_mode_pkg
`default_nettype wire

// ### src/flash_mode_reset_command_logic.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_mode_regs.svh"

// Overview of operation
// - Commands refused for 448 us after wake
// - Wake delay is (count+1) times unit
// - Power-up status follows last nonvolatile value
// - 50h enables and activates volatile copy
// - Status mixes volatile and nonvolatile bits
// - Reset needs 66h then 99h
// - Reset pair accepted on current lanes
// - Resets and power cycle leave 4-byte mode
// - B7h enters 4-byte mode, no enable
// - Dedicated opcodes always carry four bytes
// - Hold/reset disable reported as zero
// - Table bytes 137h..13Fh fixed values
// - B9h enters deep sleep, no exit opcode
module flash_mode_reset_command_logic #(
  parameter int WAKE_CYCLES = `WAKE_CYCLES
) (
  // Clock and power-on reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Hardware reset pin
  input  wire logic        hwReset_n,
  // Nonvolatile store of status register 1
  input  wire logic [7:0]  nvStored,
  output logic             nvWrite,
  output logic      [7:0]  nvWriteData
);

  localparam logic [7:0] PT [0:8] = '{8'h5c, 8'h00, 8'h00, 8'h00, 8'hff,
                                      8'hf9, 8'h10, 8'hf8, 8'ha1};
  localparam logic [15:0] WAKE_LOAD = 16'(WAKE_CYCLES);
  localparam logic [7:0] VMASK = `SR1_VOL_MASK;

  flash_mode_pkg::power_t    state;
  flash_mode_pkg::power_t    next_state;
  flash_mode_pkg::status_t   stat;
  flash_mode_pkg::cmd_info_t info;

  logic        ack;
  logic [1:0]  laneMode;
  logic [8:0]  paramAddr;
  logic [15:0] wakeCount;
  logic        rstEnable;
  logic        addr4;
  logic        wel;
  logic        volWe;
  logic        volActive;
  logic [7:0]  volSr1;
  logic        cmdRefused;

  // Dedicated opcodes carry four address bytes whatever the mode
  function automatic logic [2:0] addrLen(input logic [7:0] op, input logic mode4);
    case (op)
      8'h13, 8'h0c, 8'h12, 8'h21, 8'hdc: addrLen = 3'h4;
      8'h03, 8'h0b, 8'h02, 8'h20, 8'hd8: addrLen = mode4 ? 3'h4 : 3'h3;
      default:                           addrLen = 3'h0;
    endcase
  endfunction : addrLen

  // Bus decode: one wait cycle per access
  wire       request  = read | write;
  wire       wrTake   = write & ack;
  wire       rdTake   = read & ack;
  wire [7:0] opcode   = writedata[`CMD_OP_MSB:0];
  wire [1:0] cmdLane  = writedata[`CMD_LANE_LSB+1:`CMD_LANE_LSB];
  wire       cmdTake  = wrTake & (address == `OFF_CMD);
  wire       laneOk   = cmdLane == laneMode;
  wire       isActive = state == flash_mode_pkg::ACTIVE;
  wire       cmdLive  = cmdTake & laneOk & isActive;
  wire       hwRst    = ~hwReset_n;
  wire       softRst  = cmdLive & (opcode == `OP_RST) & rstEnable;
  wire       resetAll = softRst | hwRst;
  wire       srTake   = wrTake & (address == `OFF_SR1) & isActive & (wel | volWe);
  wire       toNv     = srTake & ~volWe & wel;
  wire [7:0] sr1Eff   = volActive ? volSr1 : ((nvStored & ~VMASK) | (volSr1 & VMASK));
  wire [8:0] ptIndex  = paramAddr - `PT_BASE;
  wire       ptHit    = (paramAddr >= `PT_BASE) & (paramAddr <= `PT_LAST);
  wire [7:0] ptByte   = ptHit ? PT[ptIndex[3:0]] : 8'h00;

  assign waitrequest = request & ~ack;

  always_comb begin
    stat            = '0;
    stat.sr1        = sr1Eff;
    stat.addr4      = addr4;
    stat.deepSleep  = state == flash_mode_pkg::SLEEP;
    stat.waking     = state == flash_mode_pkg::WAKING;
    stat.wel        = wel;
    stat.volActive  = volActive;
    stat.rstEnable  = rstEnable;
    stat.cmdRefused = cmdRefused;
  end

  wire [31:0] rdMux = (address == `OFF_CFG)   ? {30'h0, laneMode} :
                      (address == `OFF_SR1)   ? {24'h0, sr1Eff} :
                      (address == `OFF_STAT)  ? {17'h0, stat} :
                      (address == `OFF_PADDR) ? {23'h0, paramAddr} :
                      (address == `OFF_PDATA) ? {24'h0, ptByte} :
                      (address == `OFF_INFO)  ? {21'h0, info} : 32'h0;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack      <= 1'b0;
      readdata <= 32'h0;
    end else begin
      ack <= request & ~ack;
      if (read & ~ack) begin
        readdata <= rdMux;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      laneMode  <= `LANE_RESET;
      paramAddr <= 9'h0;
    end else begin
      if (wrTake & (address == `OFF_CFG)) begin
        laneMode <= writedata[1:0];
      end
      if (wrTake & (address == `OFF_PADDR)) begin
        paramAddr <= writedata[8:0];
      end else if (rdTake & (address == `OFF_PDATA)) begin
        paramAddr <= paramAddr + 9'h1;
      end
    end
  end

  // Any live command other than 66h drops a pending enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstEnable <= 1'b0;
    end else if (resetAll) begin
      rstEnable <= 1'b0;
    end else if (cmdLive) begin
      rstEnable <= opcode == `OP_RSTEN;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addr4 <= 1'b0;
    end else if (resetAll) begin
      addr4 <= 1'b0;
    end else if (cmdLive & (opcode == `OP_EN4B)) begin
      addr4 <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wel   <= 1'b0;
      volWe <= 1'b0;
    end else if (resetAll | srTake) begin
      wel   <= 1'b0;
      volWe <= 1'b0;
    end else if (cmdLive) begin
      if (opcode == `OP_WREN) begin
        wel <= 1'b1;
      end else if (opcode == `OP_WRDI) begin
        wel <= 1'b0;
      end
      if (opcode == `OP_VWREN) begin
        volWe <= 1'b1;
      end
    end
  end

  // Volatile copy is lost on every reset, so the nonvolatile value returns
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      volActive <= 1'b0;
      volSr1    <= 8'h00;
    end else if (resetAll) begin
      volActive <= 1'b0;
      volSr1    <= 8'h00;
    end else if (cmdLive & (opcode == `OP_VWREN)) begin
      volActive <= 1'b1;
      if (!volActive) begin
        volSr1 <= sr1Eff;
      end
    end else if (srTake) begin
      volSr1 <= volWe ? opcode : ((volSr1 & ~VMASK) | (opcode & VMASK));
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nvWrite     <= 1'b0;
      nvWriteData <= 8'h00;
    end else begin
      nvWrite <= toNv;
      if (toNv) begin
        nvWriteData <= opcode & ~VMASK;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmdRefused <= 1'b0;
      info       <= '0;
    end else if (cmdTake) begin
      cmdRefused <= ~(laneOk & isActive);
      if (laneOk & isActive) begin
        info.opcode    <= opcode;
        info.addrBytes <= addrLen(opcode, addr4);
      end
    end
  end

  // Only a hardware reset or a power-on reset wakes the part; no exit opcode exists
  always_comb begin
    next_state = state;
    case (state)
      flash_mode_pkg::ACTIVE: begin
        if (cmdLive & (opcode == `OP_SLEEP) & ~hwRst) begin
          next_state = flash_mode_pkg::SLEEP;
        end
      end
      flash_mode_pkg::SLEEP: begin
        if (hwRst) begin
          next_state = flash_mode_pkg::WAKING;
        end
      end
      flash_mode_pkg::WAKING: begin
        if (wakeCount == 16'h1) begin
          next_state = flash_mode_pkg::ACTIVE;
        end
      end
      default: next_state = flash_mode_pkg::ACTIVE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= flash_mode_pkg::ACTIVE;
      wakeCount <= 16'h0;
    end else begin
      state <= next_state;
      if (state == flash_mode_pkg::SLEEP) begin
        wakeCount <= WAKE_LOAD;
      end else if (wakeCount != 16'h0) begin
        wakeCount <= wakeCount - 16'h1;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_bus_one_wait: assert property (request && waitrequest |=> !waitrequest)
    else $error("waitrequest held more than one cycle");
  a_reset_pair: assert property (cmdLive && opcode == `OP_RST && rstEnable |=> !addr4 && !volActive && !wel)
    else $error("reset pair did not reset state");
  a_enable_cancel: assert property (cmdLive && opcode != `OP_RSTEN && !hwRst |=> !rstEnable)
    else $error("reset enable survived another command");
  a_enter_four: assert property (cmdLive && opcode == `OP_EN4B && !resetAll |=> addr4)
    else $error("4-byte mode not entered");
  a_hw_exit: assert property (hwRst |=> !addr4 && !volActive && !rstEnable)
    else $error("hardware reset left mode state");
  a_wake_hold: assert property ($rose(state == flash_mode_pkg::WAKING) |-> (!isActive)[*8])
    else $error("device active too soon after wake");
  a_wake_count: assert property ($rose(state == flash_mode_pkg::WAKING) |-> wakeCount == WAKE_LOAD)
    else $error("wake counter loaded wrong");
  a_nv_guard: assert property (nvWrite |-> $past(wel) && !$past(volWe))
    else $error("nonvolatile write without enable");
  a_vol_override: assert property ($past(volActive) && rdTake && address == `OFF_SR1 |-> readdata[7:0] == $past(volSr1))
    else $error("volatile copy not in effect");
  a_nv_follow: assert property (!$past(volActive) && rdTake && address == `OFF_SR1 |->
                                (readdata[7:0] & ~VMASK) == ($past(nvStored) & ~VMASK))
    else $error("status not taken from nonvolatile copy");
  a_lane_match: assert property (cmdTake && !laneOk |=> $stable(rstEnable) && $stable(addr4))
    else $error("command on wrong lane width acted");
  a_hold_bit: assert property (rdTake && address == `OFF_PDATA && paramAddr == 9'h13a |-> readdata[7] == 1'b0)
    else $error("hold disable bit not zero");
  a_sleep_enter: assert property (cmdLive && opcode == `OP_SLEEP && !hwRst |=> state == flash_mode_pkg::SLEEP)
    else $error("deep sleep not entered");
  a_sleep_refuse: assert property (cmdTake && !isActive && !hwRst |=> cmdRefused && $stable(addr4))
    else $error("command acted while asleep or waking");
  a_nv_data: assert property (nvWrite |-> nvWriteData == ($past(opcode) & ~VMASK))
    else $error("nonvolatile data carries volatile bits");
  a_vol_load: assert property (cmdLive && opcode == `OP_VWREN && !volActive && !hwRst |=> volSr1 == $past(sr1Eff))
    else $error("volatile copy not loaded on activation");
  a_four_dedicated: assert property (cmdLive && opcode == 8'h13 |=> info.addrBytes == 3'h4)
    else $error("dedicated opcode without four address bytes");

endmodule : flash_mode_reset_command_logic
`default_nettype wire

// ### verification/nv_store_model.sv
`timescale 1ns/1ps
`default_nettype none
module nv_store_model #(
  parameter logic [7:0] INIT = 8'ha4
) (
  // Clock
  input  wire logic       mclk,
  // Store port
  input  wire logic       nvWrite,
  input  wire logic [7:0] nvWriteData,
  output var  logic [7:0] nvStored
);
  // Not reset by rst_n: the content survives a power cycle
  initial nvStored = INIT;
  always @(posedge mclk) begin
    if (nvWrite === 1'b1) begin
      nvStored <= nvWriteData;
    end
  end
endmodule : nv_store_model
`default_nettype wire

// ### verification/flash_mode_reset_command_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_mode_reset_command_logic_tb;
  localparam int WAKE = 20;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic        hwReset_n = 1'b1;
  logic [4:0]  address = 5'h00;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        nvWrite;
  logic [7:0]  nvWriteData;
  logic [7:0]  nv;
  logic [31:0] rdWord;
  logic [31:0] nvCount = 32'h0;
  logic [1:0]  lane = 2'h0;
  int          n_mismatch = 0;
  int          tests_run = 0;
  logic [7:0]  tbl [10] = '{8'h5c, 8'h00, 8'h00, 8'h00, 8'hff, 8'hf9, 8'h10, 8'hf8, 8'ha1, 8'h00};
  logic [7:0]  ops [10] = '{8'h13, 8'h0c, 8'h12, 8'h21, 8'hdc, 8'h03, 8'h0b, 8'h02, 8'h20, 8'hd8};

  flash_mode_reset_command_logic #(.WAKE_CYCLES(WAKE)) dut (
    .mclk(mclk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .hwReset_n(hwReset_n), .nvStored(nv), .nvWrite(nvWrite), .nvWriteData(nvWriteData));
  nv_store_model u_nv (.mclk(mclk), .nvWrite(nvWrite), .nvWriteData(nvWriteData), .nvStored(nv));

  initial begin
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (nvWrite === 1'b1) nvCount <= nvCount + 1;
  end

  task automatic acc(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge mclk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    do begin
      @(posedge mclk);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    rdWord = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (k == 20) begin
      n_mismatch++;
      summarize;
    end
  endtask : acc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] op);
    acc(1'b1, 5'h00, {22'h0, lane, op});
  endtask : cmd
  task automatic rd(input logic [4:0] a);
    acc(1'b0, a, 32'h0);
  endtask : rd
  // Flags: rstEnable, volActive, wel, waking, deepSleep, addr4
  task automatic st(input logic [5:0] e);
    rd(5'h0c);
    chk(rdWord[13:8], e);
  endtask : st
  task automatic hw;
    @(posedge mclk);
    hwReset_n <= 1'b0;
    @(posedge mclk);
    hwReset_n <= 1'b1;
  endtask : hw
  task automatic info(input logic [2:0] addressed);
    for (int i = 0; i < 10; i++) begin
      cmd(ops[i]);
      rd(5'h18);
      chk(rdWord[10:0], {(i < 5) ? 3'h4 : addressed, ops[i]});
    end
  endtask : info

  task summarize;
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    summarize;
  end

  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rd(5'h08); chk(rdWord, 32'ha4);
    st(6'h00);
    acc(1'b1, 5'h08, 32'h5b); rd(5'h08); chk(rdWord, 32'ha4);
    chk(nvCount, 32'h0);
    cmd(8'h06); st(6'h08);
    acc(1'b1, 5'h08, 32'h5b); rd(5'h08); chk(rdWord, 32'h5b);
    chk({24'h0, nv}, 32'h58); chk(nvCount, 32'h1); st(6'h00);
    cmd(8'h06); cmd(8'h04); acc(1'b1, 5'h08, 32'h11); rd(5'h08); chk(rdWord, 32'h5b);
    cmd(8'h50); acc(1'b1, 5'h08, 32'hc6); rd(5'h08); chk(rdWord, 32'hc6);
    chk(nvCount, 32'h1); st(6'h10);
    cmd(8'hb7); st(6'h11);
    info(3'h4);
    cmd(8'h66); cmd(8'h06); cmd(8'h99); st(6'h19);
    cmd(8'h66); st(6'h39); cmd(8'h99); st(6'h00);
    rd(5'h08); chk(rdWord, 32'h58);
    info(3'h3);
    acc(1'b1, 5'h04, 32'h2); rd(5'h04); chk(rdWord[1:0], 2'h2);
    cmd(8'hb7); rd(5'h0c); chk(rdWord[14:8], 7'h40);
    lane = 2'h2;
    cmd(8'hb7); cmd(8'h66); st(6'h21); cmd(8'h99); st(6'h00);
    lane = 2'h0;
    acc(1'b1, 5'h04, 32'h0);
    cmd(8'hb7); hw; st(6'h00);
    acc(1'b1, 5'h10, 32'h137);
    for (int i = 0; i < 10; i++) begin
      rd(5'h14); chk(rdWord, {24'h0, tbl[i]});
    end
    rd(5'h1c); chk(rdWord, 32'h0);
    cmd(8'hb9); st(6'h02); cmd(8'hb7); st(6'h02);
    hw; st(6'h04); cmd(8'hb7); st(6'h04);
    repeat (WAKE) @(posedge mclk);
    st(6'h00); cmd(8'hb7); st(6'h01);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    st(6'h00);
    rd(5'h08); chk(rdWord, 32'h58);
    summarize;
  end
endmodule : flash_mode_reset_command_logic_tb
`default_nettype wire
